/* File: design/ddc_link_tx.sv */
// decimation select, gain boost, sample packing and the link layer front of the serial transmitter
// assumes filtered i/q samples arrive on the core clock; handshake and sysref are pins
// and are synchronised here; the serializer takes one 32-bit beat per cycle when ready
`timescale 1ns/1ps

module ddc_link_tx
  import ddc_link_pkg::*;
(
  input  wire logic                  i_core_clk,               // sampling/core clock, also serializer clock
  input  wire logic                  i_rstn,                   // async reset, active low
  input  wire logic [MODE_W-1:0]     i_link_mode_select,       // [2:0] decimation, [3] 64b66b
  input  wire logic                  i_gain_boost,             // ddc gain boost enable
  input  wire logic                  i_fec_enable,             // fec request, 64b66b only
  input  wire logic                  i_sync_nco_enable,        // handshake drives mixer sync in 64b66b
  input  wire logic [LANE_CNT_W-1:0] i_lane_count,             // lanes in use, 1..16
  input  wire logic                  i_sync_n,                 // handshake pin, active low
  input  wire logic                  i_sysref,                 // sysref pin
  input  wire logic                  i_sample_valid,           // filtered sample present
  input  wire logic [SAMPLE_W-1:0]   i_sample_i,               // in-phase (real in bypass)
  input  wire logic [SAMPLE_W-1:0]   i_sample_q,               // quadrature
  input  wire logic                  i_overrange_flag_first,   // first threshold flag
  input  wire logic                  i_overrange_flag_second,  // second threshold flag
  input  wire logic                  i_tx_ready,               // serializer takes data beats
  output logic                       o_sample_ready,           // sample accepted this cycle
  output logic                       o_tx_valid,               // beat is live
  output logic [FIFO_W-1:0]          o_tx_data,                // four octets
  output logic [3:0]                 o_tx_ctrl,                // per-octet control flag
  output logic [1:0]                 o_tx_header,              // 64b66b sync header
  output logic [LANE_IDX_W-1:0]      o_lane_index,             // lane carrying this beat
  output logic                       o_fec_active,             // fec applied
  output logic                       o_link_up,                // link in data phase
  output logic                       o_lmfc_edge,              // multiframe/multiblock boundary
  output logic                       o_nco_sync                // mixer sync pulse
);

  // decimation code to last count of the keep-one-in-n counter
  function automatic logic [DEC_CNT_W-1:0] dec_last(input logic [DEC_W-1:0] code);
    case (code)
      DEC_BY4:  dec_last = 5'h03;
      DEC_BY8:  dec_last = 5'h07;
      DEC_BY16: dec_last = 5'h0f;
      DEC_BY32: dec_last = 5'h1f;
      default:  dec_last = 5'h00;
    endcase
  endfunction : dec_last

  function automatic logic is_complex(input logic [DEC_W-1:0] code);
    is_complex = (dec_last(code) != 5'h00);
  endfunction : is_complex

  stream_if #(.W(FIFO_W)) fill ();
  stream_if #(.W(FIFO_W)) drain ();

  stream_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .wr         (fill),
    .rd         (drain)
  );

  // pin synchronisers; only the second stage and later are looked at
  logic sync_meta, sync_s, sync_d;
  logic sref_meta, sref_s, sref_d;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_meta <= 1'b1;
      sync_s    <= 1'b1;
      sync_d    <= 1'b1;
      sref_meta <= 1'b0;
      sref_s    <= 1'b0;
      sref_d    <= 1'b0;
    end else begin
      sync_meta <= i_sync_n;
      sync_s    <= sync_meta;
      sync_d    <= sync_s;
      sref_meta <= i_sysref;
      sref_s    <= sref_meta;
      sref_d    <= sref_s;
    end
  end

  logic [DEC_W-1:0] dec_code;
  logic             enc64;
  logic             sysref_rise;
  assign dec_code    = i_link_mode_select[DEC_LSB +: DEC_W];
  assign enc64       = i_link_mode_select[ENC_BIT];
  assign sysref_rise = sref_s && !sref_d;

  // sample path
  logic [SAMPLE_W-1:0]  boost_i, boost_q;
  logic [DEC_CNT_W-1:0] dec_cnt, next_dec_cnt;
  logic                 wr_valid, next_wr_valid;
  logic [FIFO_W-1:0]    wr_data, next_wr_data;
  logic                 next_sample_ready;
  logic                 take;

  gain_boost u_boost_i (
    .i_data  (i_sample_i),
    .i_boost (i_gain_boost),
    .o_data  (boost_i)
  );

  gain_boost u_boost_q (
    .i_data  (i_sample_q),
    .i_boost (i_gain_boost),
    .o_data  (boost_q)
  );

  assign fill.valid = wr_valid;
  assign fill.data  = wr_data;

  always_comb begin
    take              = i_sample_valid && o_sample_ready;
    next_dec_cnt      = dec_cnt;
    next_wr_valid     = wr_valid && !fill.ready;
    next_wr_data      = wr_data;
    if (take) begin
      if (dec_cnt >= dec_last(dec_code)) begin
        next_dec_cnt  = '0;
        next_wr_valid = 1'b1;
        if (is_complex(dec_code)) begin
          next_wr_data = {boost_i, i_overrange_flag_first, boost_q, i_overrange_flag_second};
        end else begin
          // bypass: real word, no filter so no boost
          next_wr_data = {i_sample_i, i_overrange_flag_first, HALF_W'(0)};
        end
      end else begin
        next_dec_cnt = dec_cnt + 1'b1;
      end
    end
    // one word in hand at a time; the fifo's full flag backs up to the source
    next_sample_ready = !next_wr_valid;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dec_cnt        <= '0;
      wr_valid       <= 1'b0;
      wr_data        <= WORD_RST;
      o_sample_ready <= 1'b0;
    end else begin
      dec_cnt        <= next_dec_cnt;
      wr_valid       <= next_wr_valid;
      wr_data        <= next_wr_data;
      o_sample_ready <= next_sample_ready;
    end
  end

  // multiframe (8b10b) / extended multiblock (64b66b) counter
  logic [MF_CNT_W-1:0] mf_cnt, next_mf_cnt;
  logic                next_lmfc_edge;

  always_comb begin
    if (sysref_rise) begin
      next_mf_cnt = '0;
    end else if (mf_cnt >= (enc64 ? LEMC_LAST : LMFC_LAST)) begin
      next_mf_cnt = '0;
    end else begin
      next_mf_cnt = mf_cnt + 1'b1;
    end
    next_lmfc_edge = (next_mf_cnt == '0);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mf_cnt      <= '0;
      o_lmfc_edge <= 1'b0;
    end else begin
      mf_cnt      <= next_mf_cnt;
      o_lmfc_edge <= next_lmfc_edge;
    end
  end

  // link state machine
  link_state_t          state, next_state;
  logic                 enc_q;
  logic [2:0]           ilas_mf, next_ilas_mf;
  logic                 next_tx_valid;
  logic [FIFO_W-1:0]    next_tx_data;
  logic [3:0]           next_tx_ctrl;
  logic [1:0]           next_tx_header;
  logic [LANE_IDX_W-1:0] next_lane;
  logic [LANE_IDX_W-1:0] lane_last;
  logic                 next_nco_sync;
  logic                 beat;

  assign lane_last = (i_lane_count == '0 || i_lane_count > LANE_CNT_W'(16)) ?
                     LANE_IDX_W'(15) : LANE_IDX_W'(i_lane_count - 1'b1);

  // fifo drains only in the data phase and only when the serializer takes it
  assign drain.ready = (state == ST_DATA) && i_tx_ready;

  always_comb begin
    next_state     = state;
    next_ilas_mf   = ilas_mf;
    next_tx_valid  = 1'b1;
    next_tx_data   = o_tx_data;
    next_tx_ctrl   = o_tx_ctrl;
    next_tx_header = o_tx_header;
    next_lane      = o_lane_index;
    beat           = 1'b0;
    // handshake only serves mixer sync in 64b66b
    next_nco_sync  = enc64 && i_sync_nco_enable && !sync_s && sync_d;

    case (state)
      ST_CGS: begin
        if (enc64) begin
          next_state = ST_BLOCK_WAIT;
        end else if (sync_s) begin
          next_state = ST_ILAS_WAIT;
        end
      end
      ST_ILAS_WAIT: begin
        if (!sync_s) begin
          next_state = ST_CGS;
        end else if (next_lmfc_edge) begin
          next_state   = ST_ILAS;
          next_ilas_mf = '0;
        end
      end
      ST_ILAS: begin
        if (!sync_s) begin
          next_state = ST_CGS;
        end else if (mf_cnt == LMFC_LAST) begin
          if (ilas_mf == ILAS_MF_LAST) begin
            next_state = ST_DATA;
          end
          next_ilas_mf = ilas_mf + 1'b1;
        end
      end
      ST_DATA: begin
        if (!enc64 && !sync_s) begin
          next_state = ST_CGS;
        end
      end
      ST_BLOCK_WAIT: begin
        // no handshake: start on the next extended multiblock edge
        if (next_lmfc_edge) begin
          next_state = ST_DATA;
        end
      end
      default: begin
        next_state = ST_CGS;
      end
    endcase
    if (enc64 != enc_q) begin
      next_state = enc64 ? ST_BLOCK_WAIT : ST_CGS;
    end

    // beat content for the state being left this cycle
    case (state)
      ST_CGS: begin
        next_tx_data   = {4{K28_5}};
        next_tx_ctrl   = 4'hf;
        next_tx_header = HDR_NONE;
      end
      ST_ILAS: begin
        next_tx_data   = {4{5'h00, ilas_mf}};
        next_tx_ctrl   = 4'h0;
        next_tx_header = HDR_NONE;
        if (mf_cnt == '0) begin
          next_tx_data[7:0] = K28_0;
          next_tx_ctrl[0]   = 1'b1;
        end else if (mf_cnt == LMFC_LAST) begin
          next_tx_data[31:24] = K28_3;
          next_tx_ctrl[3]     = 1'b1;
        end
      end
      ST_DATA: begin
        beat          = drain.valid && i_tx_ready;
        next_tx_valid = beat;
        if (beat) begin
          next_tx_data   = drain.data;
          next_tx_ctrl   = CTRL_RST;
          next_tx_header = enc64 ? HDR_DATA : HDR_NONE;
        end
      end
      default: begin
        // waiting phases: commas keep 8b10b receivers locked
        next_tx_data   = enc64 ? WORD_RST : {4{K28_5}};
        next_tx_ctrl   = enc64 ? CTRL_RST : 4'hf;
        next_tx_header = HDR_NONE;
        next_tx_valid  = !enc64;
      end
    endcase

    // beats rotate over the lanes of this one link
    if (beat) begin
      next_lane = (o_lane_index >= lane_last) ? '0 : o_lane_index + 1'b1;
    end else if (state != ST_DATA) begin
      next_lane = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state        <= ST_CGS;
      enc_q        <= 1'b0;
      ilas_mf      <= '0;
      o_tx_valid   <= 1'b0;
      o_tx_data    <= WORD_RST;
      o_tx_ctrl    <= CTRL_RST;
      o_tx_header  <= HDR_NONE;
      o_lane_index <= '0;
      o_fec_active <= 1'b0;
      o_link_up    <= 1'b0;
      o_nco_sync   <= 1'b0;
    end else begin
      state        <= next_state;
      enc_q        <= enc64;
      ilas_mf      <= next_ilas_mf;
      o_tx_valid   <= next_tx_valid;
      o_tx_data    <= next_tx_data;
      o_tx_ctrl    <= next_tx_ctrl;
      o_tx_header  <= next_tx_header;
      o_lane_index <= next_lane;
      // no crc3, command channel or 64b80b path exists at all
      o_fec_active <= enc64 && i_fec_enable;
      o_link_up    <= (next_state == ST_DATA);
      o_nco_sync   <= next_nco_sync;
    end
  end

  // every register above runs on i_core_clk, no separate link clock
endmodule : ddc_link_tx

/* File: design/ddc_link_pkg.sv */
// constants, field layouts and state type shared by the ddc and link transmitter
// assumes one frame per core clock and a 32-bit word (four octets) per transmit beat
package ddc_link_pkg;
  localparam int SAMPLE_W    = 15;
  localparam int HALF_W      = 16;
  localparam int FIFO_W      = 32;
  localparam int FIFO_DEPTH  = 8;
  localparam int LANE_IDX_W  = 4;
  localparam int LANE_CNT_W  = 5;
  localparam int MODE_W      = 4;
  localparam int DEC_LSB     = 0;
  localparam int DEC_W       = 3;
  localparam int ENC_BIT     = 3;
  localparam int DEC_CNT_W   = 5;
  localparam int MF_CNT_W    = 8;

  // decimation codes in the mode selection
  localparam logic [DEC_W-1:0] DEC_BYPASS = 3'h0;
  localparam logic [DEC_W-1:0] DEC_BY4    = 3'h1;
  localparam logic [DEC_W-1:0] DEC_BY8    = 3'h2;
  localparam logic [DEC_W-1:0] DEC_BY16   = 3'h3;
  localparam logic [DEC_W-1:0] DEC_BY32   = 3'h4;

  // special characters (8b10b control octets)
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_3 = 8'h7c;

  // last counts of the multiframe and extended multiblock in core cycles, and of the ilas in multiframes
  localparam logic [MF_CNT_W-1:0] LMFC_LAST = 8'h1f;
  localparam logic [MF_CNT_W-1:0] LEMC_LAST = 8'h3f;
  localparam logic [2:0]          ILAS_MF_LAST = 3'h3;

  // 64b66b sync headers
  localparam logic [1:0] HDR_DATA = 2'h1;
  localparam logic [1:0] HDR_NONE = 2'h0;

  // reset values
  localparam logic [FIFO_W-1:0]   WORD_RST = 32'h0000_0000;
  localparam logic [3:0]          CTRL_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_CGS,
    ST_ILAS_WAIT,
    ST_ILAS,
    ST_DATA,
    ST_BLOCK_WAIT
  } link_state_t;
endpackage : ddc_link_pkg

/* File: design/stream_if.sv */
// valid/ready word carrier between the datapath, the fifo and the link layer
// assumes both ends share one clock
`timescale 1ns/1ps
interface stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : stream_if

/* File: design/gain_boost.sv */
// saturating 6.02 dB boost of one 15-bit two's complement filter output
// assumes a combinational slot ahead of a register in the caller
`timescale 1ns/1ps
module gain_boost (
  input  wire logic [14:0] i_data,   // filter output
  input  wire logic        i_boost,  // 1: double the value
  output logic      [14:0] o_data    // boosted value
);
  always_comb begin
    if (!i_boost) begin
      o_data = i_data;
    end else if (i_data[14] != i_data[13]) begin
      // clamp instead of wrapping, a wrapped peak flips sign
      o_data = i_data[14] ? 15'h4000 : 15'h3fff;
    end else begin
      o_data = {i_data[13:0], 1'b0};
    end
  end
endmodule : gain_boost

/* File: design/stream_fifo.sv */
// flop-based fifo with registered full and empty flags
// assumes writer and reader on the same clock
`timescale 1ns/1ps
module stream_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic i_core_clk,  // core clock
  input  wire logic i_rstn,      // async reset, active low
  stream_if.dst     wr,          // fill side
  stream_if.src     rd           // drain side
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [W-1:0]  next_mem [DEPTH];
  logic [PW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [CW-1:0] count, next_count;
  logic          full, next_full, empty, next_empty;
  logic          push, pop;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr];

  always_comb begin
    push      = wr.valid && !full;
    pop       = rd.ready && !empty;
    next_mem  = mem;
    next_wptr = wptr;
    next_rptr = rptr;
    if (push) begin
      next_mem[wptr] = wr.data;
      next_wptr = (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
    end
    if (pop) begin
      next_rptr = (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
    end
    next_count = count + CW'(push) - CW'(pop);
    next_full  = (next_count == CW'(DEPTH));
    next_empty = (next_count == '0);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem[k] <= '0;
      end
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
      full  <= 1'b0;
      empty <= 1'b1;
    end else begin
      mem   <= next_mem;
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
      full  <= next_full;
      empty <= next_empty;
    end
  end
endmodule : stream_fifo

/* File: verification/ddc_link_tx_chk.sv */
// assertions on the top ports of the ddc and link transmitter
// assumes a bind from the bench top and mode inputs held steady between tests
`timescale 1ns/1ps
module ddc_link_tx_chk
  import ddc_link_pkg::*;
(
  input wire logic                  i_core_clk,          // clock
  input wire logic                  i_rstn,              // reset
  input wire logic [MODE_W-1:0]     i_link_mode_select,  // mode
  input wire logic                  i_fec_enable,        // fec
  input wire logic                  i_sync_nco_enable,   // mixer sync
  input wire logic [LANE_CNT_W-1:0] i_lane_count,        // lanes
  input wire logic                  i_sync_n,            // handshake
  input wire logic                  i_sysref,            // sysref
  input wire logic                  i_sample_valid,      // sample in
  input wire logic                  o_sample_ready,      // sample taken
  input wire logic                  o_tx_valid,          // beat live
  input wire logic [FIFO_W-1:0]     o_tx_data,           // beat
  input wire logic [3:0]            o_tx_ctrl,           // control
  input wire logic [1:0]            o_tx_header,         // header
  input wire logic [LANE_IDX_W-1:0] o_lane_index,        // lane
  input wire logic                  o_fec_active,        // fec on
  input wire logic                  o_link_up,           // data phase
  input wire logic                  o_lmfc_edge,         // boundary
  input wire logic                  o_nco_sync           // mixer pulse
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  // six cycles cover the two sync flops and the state register
  AST_COMMA_STREAM: assert property (
    (!i_link_mode_select[ENC_BIT] && !i_sync_n && $stable(i_link_mode_select))[*6] |->
      o_tx_valid && o_tx_data == {4{K28_5}} && o_tx_ctrl == 4'hf && !o_link_up)
    else $error("handshake low without comma stream");
  AST_HEADER_64: assert property (
    i_link_mode_select[ENC_BIT] && $past(i_link_mode_select, 4) == i_link_mode_select && o_tx_valid && o_link_up
      |-> o_tx_header == HDR_DATA)
    else $error("64b66b beat without data header");
  AST_HEADER_8B: assert property (
    !i_link_mode_select[ENC_BIT] && $past(i_link_mode_select, 4) == i_link_mode_select |-> o_tx_header == HDR_NONE)
    else $error("header set in 8b10b mode");
  AST_FEC_FOLLOW: assert property (
    o_fec_active == $past(i_fec_enable && i_link_mode_select[ENC_BIT]))
    else $error("fec flag does not follow request");
  AST_NCO_PULSE: assert property (
    i_link_mode_select[ENC_BIT] && i_sync_nco_enable && $fell(i_sync_n) |-> ##[1:6] o_nco_sync)
    else $error("no mixer sync pulse");
  AST_SYSREF_EDGE: assert property (
    $rose(i_sysref) |-> ##[1:6] o_lmfc_edge)
    else $error("sysref gave no boundary");
  AST_LANE_RANGE: assert property (
    o_tx_valid && o_link_up && $past(i_lane_count, 2) == i_lane_count && i_lane_count inside {[1:16]}
      |-> o_lane_index < i_lane_count)
    else $error("lane index beyond lane count");
  AST_BYPASS_READY: assert property (
    i_link_mode_select[DEC_W-1:0] == DEC_BYPASS && $stable(i_link_mode_select) && i_sample_valid && o_sample_ready
      |=> !o_sample_ready)
    else $error("bypass sample not kept");
endmodule : ddc_link_tx_chk

/* File: verification/link_rx_model.sv */
// receiving logic device: drives the handshake and the serializer ready
// assumes the bench asks for the link and stalls the receiver through two inputs
`timescale 1ns/1ps
module link_rx_model
  import ddc_link_pkg::*;
(
  input  wire logic        i_core_clk,   // core clock
  input  wire logic        i_rstn,       // reset, active low
  input  wire logic        i_tx_valid,   // beat live
  input  wire logic [31:0] i_tx_data,    // beat octets
  input  wire logic [3:0]  i_tx_ctrl,    // control flags
  input  wire logic        i_lmfc_edge,  // multiframe boundary
  input  wire logic        i_want_link,  // bench asks for the link
  input  wire logic        i_mode64,     // 64b66b mode
  input  wire logic        i_stall,      // bench stalls the receiver
  output logic             o_sync_n,     // handshake, active low
  output logic             o_tx_ready    // takes beats
);
  logic [2:0] commas;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      commas   <= 3'h0;
      o_sync_n <= 1'b0;
    end else if (i_mode64) begin
      o_sync_n <= i_want_link;  // only mixer sync rides on it here
    end else if (!i_want_link) begin
      commas   <= 3'h0;
      o_sync_n <= 1'b0;  // low asks for code group sync
    end else begin
      if (i_tx_valid && i_tx_data == {4{K28_5}} && i_tx_ctrl == 4'hf && commas != 3'h4)
        commas <= commas + 3'h1;
      if (commas == 3'h4 && i_lmfc_edge)
        o_sync_n <= 1'b1;  // release on the boundary after four commas
    end
  end

  assign o_tx_ready = !i_stall;  // a slow receiver just stalls
endmodule : link_rx_model

/* File: verification/ddc_link_tx_bench.sv */
// self-checking bench for the ddc and link transmitter with a receiver model
// assumes a 10 MHz core clock and no second reset
`timescale 1ns/1ps
module ddc_link_tx_bench;
  import ddc_link_pkg::*;
  logic                  i_core_clk = 1'b0;
  logic                  i_rstn = 1'b0;
  logic [MODE_W-1:0]     i_link_mode_select = 4'h0;
  logic                  i_gain_boost = 1'b0;
  logic                  i_fec_enable = 1'b0;
  logic                  i_sync_nco_enable = 1'b0;
  logic [LANE_CNT_W-1:0] i_lane_count = 5'h10;
  logic                  i_sysref = 1'b0;
  logic                  i_sample_valid = 1'b0;
  logic [SAMPLE_W-1:0]   i_sample_i = 15'h0000;
  logic [SAMPLE_W-1:0]   i_sample_q = 15'h0000;
  logic                  i_overrange_flag_first = 1'b1;
  logic                  i_overrange_flag_second = 1'b1;
  logic                  want_link = 1'b0;
  logic                  stall = 1'b0;
  logic                  i_sync_n, i_tx_ready, o_sample_ready, o_tx_valid, o_fec_active, o_link_up;
  logic                  o_lmfc_edge, o_nco_sync;
  logic [FIFO_W-1:0]     o_tx_data;
  logic [3:0]            o_tx_ctrl;
  logic [1:0]            o_tx_header;
  logic [LANE_IDX_W-1:0] o_lane_index;
  int                    fails = 0;
  int                    tests_run = 0;
  int                    cycles = 0;

  ddc_link_tx dut (.i_core_clk, .i_rstn, .i_link_mode_select, .i_gain_boost, .i_fec_enable, .i_sync_nco_enable,
    .i_lane_count, .i_sync_n, .i_sysref, .i_sample_valid, .i_sample_i, .i_sample_q, .i_overrange_flag_first,
    .i_overrange_flag_second, .i_tx_ready, .o_sample_ready, .o_tx_valid, .o_tx_data, .o_tx_ctrl, .o_tx_header,
    .o_lane_index, .o_fec_active, .o_link_up, .o_lmfc_edge, .o_nco_sync);
  link_rx_model rx (.i_core_clk, .i_rstn, .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_ctrl(o_tx_ctrl),
    .i_lmfc_edge(o_lmfc_edge), .i_want_link(want_link), .i_mode64(i_link_mode_select[ENC_BIT]),
    .i_stall(stall), .o_sync_n(i_sync_n), .o_tx_ready(i_tx_ready));

  always #50 i_core_clk = ~i_core_clk;

  task automatic summarize;
    $display("counts: %0d compared, %0d bad", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // the run needs well under 5000 cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("BAD %0t run hung", $time);
      summarize;
    end
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // ready is registered, so its mid-cycle value holds at the next edge
  task automatic send(input logic [14:0] si, input logic [14:0] sq, output bit ok);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_sample_valid <= 1'b1;
    i_sample_i     <= si;
    i_sample_q     <= sq;
    @(negedge i_core_clk);
    while (o_sample_ready !== 1'b1 && n < 20) begin
      @(negedge i_core_clk);
      n++;
    end
    ok = (n < 20);
    @(posedge i_core_clk);
    i_sample_valid <= 1'b0;
  endtask : send

  task automatic grab(output logic [31:0] d, output logic [1:0] h);
    int n;
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (!(o_tx_valid === 1'b1 && o_link_up === 1'b1 && i_tx_ready === 1'b1) && n < 300);
    d = o_tx_data;
    h = o_tx_header;
  endtask : grab

  task automatic wait_for(input bit lmfc, output int n);
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while ((lmfc ? o_lmfc_edge : o_link_up) !== 1'b1 && n < 400);
  endtask : wait_for

  task automatic t_cgs_ilas;
    bit saw_r;
    bit saw_a;
    int n;
    repeat (8) @(negedge i_core_clk);
    check(o_tx_data, {4{K28_5}}, "comma octets");
    check(o_tx_ctrl, 4'hf, "comma control");
    want_link <= 1'b1;
    saw_r = 0;
    saw_a = 0;
    for (n = 0; n < 400 && o_link_up !== 1'b1; n++) begin
      @(negedge i_core_clk);
      saw_r |= (o_tx_ctrl === 4'h1 && o_tx_data[7:0] === K28_0);
      saw_a |= (o_tx_ctrl === 4'h8 && o_tx_data[31:24] === K28_3);
    end
    check(o_link_up, 1'b1, "link up");
    check({saw_r, saw_a}, 2'h3, "alignment markers");
    $display("cgs and ilas done");
  endtask : t_cgs_ilas

  task automatic t_formats;
    logic [14:0] vi [4] = '{15'h0123, 15'h0123, 15'h3000, 15'h3000};
    logic [14:0] vq [4] = '{15'h7ffe, 15'h7ffe, 15'h5000, 15'h5000};
    logic [14:0] ei [4] = '{15'h0123, 15'h0246, 15'h3000, 15'h3fff};
    logic [14:0] eq [4] = '{15'h7ffe, 15'h7ffc, 15'h5000, 15'h4000};
    logic [31:0] d;
    logic [1:0]  h;
    bit          ok;
    send(15'h2a5c, 15'h1111, ok);
    grab(d, h);
    check(d, {15'h2a5c, 1'b1, 16'h0000}, "bypass word");
    // boost only with complex decimation, where the image is filtered
    for (int k = 0; k < 4; k++) begin
      i_link_mode_select <= {1'b0, DEC_BY4 + 3'(k)};
      i_gain_boost       <= k[0];
      i_overrange_flag_first <= k[1];
      for (int s = 0; s < (4 << k); s++)
        send(vi[k], vq[k], ok);
      grab(d, h);
      check(d, {ei[k], k[1], eq[k], 1'b1}, "decimated word");
    end
    i_link_mode_select <= {1'b0, DEC_BYPASS};
    i_gain_boost       <= 1'b0;
    $display("formats done");
  endtask : t_formats

  task automatic t_fifo;
    logic [31:0] d;
    logic [1:0]  h;
    int          pushed;
    bit          ok;
    stall  <= 1'b1;
    pushed = 0;
    ok     = 1;
    while (ok && pushed < 20) begin
      send(15'(pushed), 15'h0000, ok);
      pushed += ok;
    end
    check(pushed inside {FIFO_DEPTH, FIFO_DEPTH + 1}, 1'b1, "fill depth");
    check(o_tx_valid, 1'b0, "no beat while stalled");
    stall <= 1'b0;
    for (int j = 0; j < pushed; j++) begin
      grab(d, h);
      check(d, {15'(j), 1'b1, 16'h0000}, "drain order");
    end
    $display("fifo done");
  endtask : t_fifo

  task automatic t_boundary(input int period);
    int n;
    wait_for(1'b1, n);
    repeat (10) @(posedge i_core_clk);
    i_sysref <= 1'b1;
    @(posedge i_core_clk);
    i_sysref <= 1'b0;
    wait_for(1'b1, n);
    check(n < 12, 1'b1, "boundary after sysref");
    wait_for(1'b1, n);
    check(n, period, "boundary spacing");
    $display("boundary done");
  endtask : t_boundary

  task automatic t_mode64;
    logic [31:0] d;
    logic [1:0]  h;
    bit          ok;
    int          n;
    i_link_mode_select <= {1'b1, DEC_BYPASS};
    i_fec_enable       <= 1'b1;
    i_lane_count       <= 5'h04;
    want_link          <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    wait_for(1'b0, n);
    check(o_link_up, 1'b1, "link up with handshake low");
    check(o_fec_active, 1'b1, "fec active");
    send(15'h1234, 15'h0000, ok);
    grab(d, h);
    check({h, d}, {HDR_DATA, 15'h1234, 1'b1, 16'h0000}, "64b66b beat");
    t_boundary(64);
    i_sync_nco_enable <= 1'b1;
    want_link         <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    want_link <= 1'b0;
    for (n = 0; n < 8 && o_nco_sync !== 1'b1; n++)
      @(negedge i_core_clk);
    check(n < 8, 1'b1, "mixer sync pulse");
    check(o_link_up, 1'b1, "link kept");
    $display("64b66b done");
  endtask : t_mode64

  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    t_cgs_ilas;
    t_formats;
    t_fifo;
    t_boundary(32);
    t_mode64;
    summarize;
  end
endmodule : ddc_link_tx_bench

bind ddc_link_tx ddc_link_tx_chk chk (.i_core_clk, .i_rstn, .i_link_mode_select, .i_fec_enable,
  .i_sync_nco_enable, .i_lane_count, .i_sync_n, .i_sysref, .i_sample_valid, .o_sample_ready, .o_tx_valid,
  .o_tx_data, .o_tx_ctrl, .o_tx_header, .o_lane_index, .o_fec_active, .o_link_up, .o_lmfc_edge, .o_nco_sync);
